// [hdl/bzgen_map.svh]
`ifndef BZGEN_MAP_SVH
`define BZGEN_MAP_SVH

// register byte offsets
`define BZ_CTRL_OFF    12'h000
`define BZ_PCFG_OFF    12'h004
`define BZ_STAT_OFF    12'h008

// field positions
`define BZ_PERIOD_MSB  5
`define BZ_PSC_LSB     6
`define BZ_PSC_MSB     7
`define BZ_EN_BIT      2
`define BZ_ST_LVL_BIT  6
`define BZ_ST_RUN_BIT  7

// reset values
`define BZ_CTRL_RESET  8'h00
`define BZ_PCFG_RESET  8'h00

// counter limits and prescaler ratios
`define BZ_CNT_MAX     6'h3f
`define BZ_RATIO_00    7'h01
`define BZ_RATIO_01    7'h04
`define BZ_RATIO_10    7'h10
`define BZ_RATIO_11    7'h40

`endif

// [hdl/bzgen_pkg.sv]
package bzgen_pkg;

    typedef enum logic
    {
        bz_idle,
        bz_run
    } bzgen_state_type;

    typedef logic [5:0] bzgen_count_type;
    typedef logic [6:0] bzgen_ratio_type;

endpackage : bzgen_pkg

// [hdl/bzgen_prescaler.sv]
`timescale 1ns/1ps
`default_nettype none

module bzgen_prescaler
(
    input  wire logic                     clock,
    input  wire logic                     resetn,
    input  wire logic                     clear,
    input  wire bzgen_pkg::bzgen_ratio_type ratio,
    output logic                          tick
);
    import bzgen_pkg::*;

    bzgen_ratio_type count_q;
    bzgen_ratio_type count_d;
    logic            tick_d;

    always_comb
    begin
        count_d = count_q + 7'h01;
        tick_d  = 1'b0;
        if (clear)
        begin
            count_d = 7'h00;
        end
        // >= keeps a ratio change mid-count from running away
        else if (count_q >= ratio - 7'h01)
        begin
            count_d = 7'h00;
            tick_d  = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            count_q <= 7'h00;
        end
        else
        begin
            count_q <= count_d;
        end
    end

    assign tick = tick_d;

endmodule : bzgen_prescaler

`default_nettype wire

// [hdl/bzgen_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "bzgen_map.svh"

module bzgen_top
#(
    parameter int                         ADDR_W   = 12,
    parameter bzgen_pkg::bzgen_ratio_type RATIO_00 = `BZ_RATIO_00,
    parameter bzgen_pkg::bzgen_ratio_type RATIO_01 = `BZ_RATIO_01,
    parameter bzgen_pkg::bzgen_ratio_type RATIO_10 = `BZ_RATIO_10,
    parameter bzgen_pkg::bzgen_ratio_type RATIO_11 = `BZ_RATIO_11
)
(
    input  wire logic              clock,
    input  wire logic              resetn,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic                   port_c_bit_one_pin,
    output logic                   port_c_bit_one_oe
);
    import bzgen_pkg::*;

    // register state
    logic [7:0]      buzzer_control_q;
    logic [7:0]      buzzer_control_d;
    logic [7:0]      port_c_low_config_q;
    logic [7:0]      port_c_low_config_d;
    logic [31:0]     prdata_q;
    logic [31:0]     prdata_d;
    logic            pready_q;
    logic            pready_d;
    logic            pslverr_q;
    logic            pslverr_d;

    // tone state
    bzgen_state_type state_q;
    bzgen_state_type state_d;
    bzgen_count_type count_q;
    bzgen_count_type count_d;
    logic            level_q;
    logic            level_d;
    logic            oe_q;
    logic            oe_d;

    logic            access;
    logic            commit;
    logic            hit_ctrl;
    logic            hit_pcfg;
    logic            hit_stat;
    logic            enable;
    logic            tick;
    bzgen_ratio_type ratio;
    bzgen_count_type period;
    logic [7:0]      status;

    assign access = psel & penable;
    assign commit = access & pready_q;
    assign enable = port_c_low_config_q[`BZ_EN_BIT];
    assign period = buzzer_control_q[`BZ_PERIOD_MSB:0];

    always_comb
    begin
        hit_ctrl = 1'b0;
        hit_pcfg = 1'b0;
        hit_stat = 1'b0;
        if (paddr == ADDR_W'(`BZ_CTRL_OFF))
        begin
            hit_ctrl = 1'b1;
        end
        else if (paddr == ADDR_W'(`BZ_PCFG_OFF))
        begin
            hit_pcfg = 1'b1;
        end
        else if (paddr == ADDR_W'(`BZ_STAT_OFF))
        begin
            hit_stat = 1'b1;
        end
    end

    always_comb
    begin
        status                 = {2'b00, count_q};
        status[`BZ_ST_LVL_BIT] = level_q;
        status[`BZ_ST_RUN_BIT] = (state_q == bz_run);
    end

    // apb slave: answer in the second access cycle
    always_comb
    begin
        buzzer_control_d    = buzzer_control_q;
        port_c_low_config_d = port_c_low_config_q;
        prdata_d            = prdata_q;
        pready_d            = access & ~pready_q;
        pslverr_d           = 1'b0;
        if (access && !pready_q)
        begin
            pslverr_d = ~(hit_ctrl | hit_pcfg | hit_stat);
            prdata_d  = 32'h0000_0000;
            if (!pwrite && hit_ctrl)
            begin
                prdata_d = {24'h00_0000, buzzer_control_q};
            end
            else if (!pwrite && hit_pcfg)
            begin
                prdata_d = {24'h00_0000, port_c_low_config_q};
            end
            else if (!pwrite && hit_stat)
            begin
                prdata_d = {24'h00_0000, status};
            end
        end
        if (commit && pwrite && pstrb[0])
        begin
            if (hit_ctrl)
            begin
                buzzer_control_d = pwdata[7:0];
            end
            else if (hit_pcfg)
            begin
                port_c_low_config_d = pwdata[7:0];
            end
        end
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            buzzer_control_q    <= `BZ_CTRL_RESET;
            port_c_low_config_q <= `BZ_PCFG_RESET;
            prdata_q            <= 32'h0000_0000;
            pready_q            <= 1'b0;
            pslverr_q           <= 1'b0;
        end
        else
        begin
            buzzer_control_q    <= buzzer_control_d;
            port_c_low_config_q <= port_c_low_config_d;
            prdata_q            <= prdata_d;
            pready_q            <= pready_d;
            pslverr_q           <= pslverr_d;
        end
    end

    // ratio select; the divide by two comes from the toggle
    always_comb
    begin
        case (buzzer_control_q[`BZ_PSC_MSB:`BZ_PSC_LSB])
            2'b00:   ratio = RATIO_00;
            2'b01:   ratio = RATIO_01;
            2'b10:   ratio = RATIO_10;
            default: ratio = RATIO_11;
        endcase
    end

    bzgen_prescaler u_prescaler
    (
        .clock  (clock),
        .resetn (resetn),
        .clear  (state_q != bz_run),
        .ratio  (ratio),
        .tick   (tick)
    );

    // tone generator
    always_comb
    begin
        state_d = state_q;
        count_d = count_q;
        level_d = level_q;
        case (state_q)
            bz_idle:
            begin
                count_d = 6'h00;
                level_d = 1'b0;
                if (enable)
                begin
                    state_d = bz_run;
                end
            end
            bz_run:
            begin
                if (!enable)
                begin
                    state_d = bz_idle;
                    count_d = 6'h00;
                    level_d = 1'b0;
                end
                else if (tick)
                begin
                    if (count_q == period)
                    begin
                        level_d = ~level_q;
                        count_d = 6'h00;
                    end
                    else if (count_q == `BZ_CNT_MAX)
                    begin
                        count_d = 6'h00;
                    end
                    else
                    begin
                        count_d = count_q + 6'h01;
                    end
                end
            end
            default:
            begin
                state_d = bz_idle;
            end
        endcase
        oe_d = (state_d == bz_run);
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            state_q <= bz_idle;
            count_q <= 6'h00;
            level_q <= 1'b0;
            oe_q    <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            count_q <= count_d;
            level_q <= level_d;
            oe_q    <= oe_d;
        end
    end

    assign prdata             = prdata_q;
    assign pready             = pready_q;
    assign pslverr            = pslverr_q;
    assign port_c_bit_one_pin = level_q;
    assign port_c_bit_one_oe  = oe_q;

endmodule : bzgen_top

`default_nettype wire

// [verif/bzgen_buzzer_model.sv]
`timescale 1ns/1ps
`default_nettype none
module bzgen_buzzer_model
(
    input  wire logic clock,
    input  wire logic level,
    input  wire logic drive,
    output int        half_q,
    output int        edges_q
);
    int   run_q;
    logic last_q;
    initial
    begin
        half_q = 0;
        edges_q = 0;
        run_q = 0;
        last_q = 0;
    end
    // measures clocks between toggles of the driven pin
    always @(posedge clock)
    begin
        run_q <= run_q + 1;
        last_q <= level;
        if (drive && level != last_q)
        begin
            half_q <= run_q;
            edges_q <= edges_q + 1;
            run_q <= 1;
        end
    end
endmodule : bzgen_buzzer_model
`default_nettype wire

// [verif/bzgen_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module bzgen_properties
#(
    parameter int ADDR_W = 12
)
(
    input wire logic              clock,
    input wire logic              resetn,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [31:0]       pwdata,
    input wire logic [3:0]        pstrb,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              port_c_bit_one_pin,
    input wire logic              port_c_bit_one_oe
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    wire logic cfg_wr = psel && penable && pready && pwrite && pstrb[0] && paddr == 4;
    a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
    a_ready_wait: assert property ($rose(penable) && psel |=> pready) else $error("no pready");
    a_err_unmapped: assert property (pready && paddr > 8 |-> pslverr) else $error("no pslverr");
    a_high_zero: assert property (pready |-> prdata[31:8] == 0) else $error("prdata high bits");
    a_off_low: assert property (!port_c_bit_one_oe |-> !port_c_bit_one_pin)
        else $error("pin high while off");
    a_start_low: assert property ($rose(port_c_bit_one_oe) |-> !port_c_bit_one_pin)
        else $error("enable not low");
    a_enable_on: assert property (cfg_wr && pwdata[2] |-> ##[1:2] port_c_bit_one_oe)
        else $error("enable missed");
    a_enable_off: assert property (cfg_wr && !pwdata[2] |-> ##[1:2] !port_c_bit_one_oe)
        else $error("disable missed");
    a_oe_cause: assert property (
        $changed(port_c_bit_one_oe) |-> $past(cfg_wr) || $past(cfg_wr, 2))
        else $error("enable without write");
endmodule : bzgen_properties
bind bzgen_top bzgen_properties #(.ADDR_W(ADDR_W)) i_bzgen_properties
(
    .clock              (clock),
    .resetn             (resetn),
    .paddr              (paddr),
    .psel               (psel),
    .penable            (penable),
    .pwrite             (pwrite),
    .pwdata             (pwdata),
    .pstrb              (pstrb),
    .prdata             (prdata),
    .pready             (pready),
    .pslverr            (pslverr),
    .port_c_bit_one_pin (port_c_bit_one_pin),
    .port_c_bit_one_oe  (port_c_bit_one_oe)
);
`default_nettype wire

// [verif/bzgen_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module bzgen_tb_top;
    logic        clock = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [7:0]  seed = 8'h1f, c;
    logic        pready, pslverr, pin, oe, err;
    int          err_total = 0, comparisons = 0, half, edges;
    always #50 clock = ~clock;
    bzgen_top i_bzgen_top (.clock(clock),
        .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .port_c_bit_one_pin(pin), .port_c_bit_one_oe(oe));
    bzgen_buzzer_model i_bzgen_buzzer_model (.clock(clock), .level(pin), .drive(oe),
        .half_q(half), .edges_q(edges));
    function automatic logic [7:0] lfsr(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction : lfsr
    function automatic int half_exp(input logic [7:0] v);
        int r[4] = '{1, 4, 16, 64};
        return r[v[7:6]] * (v[5:0] + 1);
    endfunction : half_exp
    task final_report;
        $display("comparisons %0d errors %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : final_report
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clock);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1;
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        if (pready !== 1'b1)
        begin
            err_total++;
            final_report();
        end
    endtask : apb
    task wait_edges(input int k);
        int n;
        int e0;
        e0 = edges;
        for (n = 0; edges < e0 + k && n < 20000; n++)
            @(posedge clock);
        if (edges < e0 + k)
        begin
            err_total++;
            final_report();
        end
    endtask : wait_edges
    initial
    begin
        repeat (2) @(posedge clock);
        resetn <= 1;
        apb(0, 0, 0);
        chk("ctrl_reset", rd, 0);
        apb(0, 4, 0);
        chk("cfg_reset", rd, 0);
        apb(0, 12'h010, 0);
        chk("unmapped_err", err, 1);
        for (int i = 0; i < 6; i++)
        begin
            c = i == 0 ? 8'hc9 : i == 1 ? 8'h3f : i == 2 ? 8'h80 : {i[1:0], seed[5:0]};
            seed = lfsr(seed);
            apb(1, 0, c);
            apb(0, 0, 0);
            chk("ctrl_rw", rd, c);
            chk("ctrl_err", err, 0);
            apb(1, 4, 4);
            wait_edges(3);
            chk("half_period", half, half_exp(c));
            wait_edges(1);
            chk("other_half", half, half_exp(c));
            chk("oe_on", oe, 1);
            apb(0, 8, 0);
            chk("running", rd[7], 1);
            apb(1, 4, 0);
            repeat (2) @(posedge clock);
            #1 chk("oe_off", oe, 0);
            chk("pin_off", pin, 0);
            apb(0, 8, 0);
            chk("idle_status", rd, 0);
        end
        final_report();
    end
endmodule : bzgen_tb_top
`default_nettype wire
